// *** verilog/sys_flag_pkg.sv ***
// Constants, carriers and state type for the system status flag unit.
`default_nettype none
package sys_flag_pkg;
  localparam int ADDR_BITS = 12;
  localparam int FLAG_COUNT = 24;
  localparam int KEY_COUNT = 8;
  localparam int INPUT_COUNT = 15;
  localparam int ANALOG_COUNT = 8;
  localparam int ANALOG_BITS = 10;
  localparam int SENSOR_COUNT = 8;
  // Clock rate and the half period of the toggle flag.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned HALF_SECOND_MS = 500;
  localparam int unsigned HALF_SECOND_CYCLES_DEF = CLK_HZ / 1000 * HALF_SECOND_MS;
  // Register byte offsets.
  localparam logic [11:0] OFF_FLAGS = 12'h000;
  localparam logic [11:0] OFF_SPECIAL = 12'h004;
  localparam logic [11:0] OFF_KEYS = 12'h008;
  localparam logic [11:0] OFF_RUN = 12'h00c;
  localparam logic [11:0] OFF_MONITOR = 12'h010;
  localparam logic [11:0] OFF_INPUTS = 12'h014;
  localparam logic [11:0] OFF_ANALOG = 12'h018;
  // Field positions.
  localparam int SPC_DISCONNECT = 0;
  localparam int SPC_BL_OFF = 1;
  localparam int SPC_BL_ON = 2;
  localparam int SPC_DISPLAY = 3;
  localparam int KEYS_STATE_LSB = 8;
  localparam int MON_ACTIVE = 0;
  localparam int MON_SEL_LSB = 4;
  localparam int MON_FORCE_LSB = 16;
  localparam int ANALOG_VAL_LSB = 16;
  localparam int KEY_CONFIRM = 0;
  localparam int KEY_CANCEL = 1;
  // Flag positions in the flag word.
  localparam int FLG_ONE = 0;
  localparam int FLG_ZERO = 1;
  localparam int FLG_TOGGLE = 2;
  localparam int FLG_CLOCK = 3;
  localparam int FLG_SUMMER = 4;
  localparam int FLG_COMM = 5;
  localparam int FLG_POWER = 6;
  localparam int FLG_ENTRY_HI = 7;
  localparam int FLG_ENTRY_LO = 8;
  localparam int FLG_RADIO_BUSY = 9;
  localparam int FLG_RADIO_OK = 10;
  localparam int FLG_CARRIER = 11;
  localparam int FLG_CELL_READY = 12;
  localparam int FLG_CELL_REMOTE = 13;
  localparam int FLG_RADIO_ERR = 14;
  localparam int FLG_SUPPLY = 15;
  localparam int FLG_SENSOR0 = 16;
  // Values after reset.
  localparam logic [3:0] SPECIAL_RST = 4'h0;
  localparam logic [7:0] AUX_RST = 8'h00;
  // Flag word in and straight after reset: the one flag and the idle low-pulse flag stand high.
  localparam logic [FLAG_COUNT-1:0] FLAGS_RST = 24'h000101;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_BITS-1:0] paddr;
    logic [31:0] pwdata;
  } apb_in_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_out_type;

  typedef struct packed {
    logic rtc_error;
    logic summer_time;
    logic fieldnet_comm_error;
    logic fieldnet_power_error;
    logic modem_carrier;
    logic cell_ready;
    logic cell_remote;
    logic ext_supply;
    logic radio_decoding;
    logic radio_error;
    logic [SENSOR_COUNT-1:0] sensor_defect;
  } status_pin_type;

  typedef struct packed {
    status_pin_type st_s1;
    status_pin_type st_s2;
    logic [KEY_COUNT-1:0] key_s1;
    logic [KEY_COUNT-1:0] key_s2;
    logic [KEY_COUNT-1:0] key_d;
    logic [INPUT_COUNT-1:0] in_s1;
    logic [INPUT_COUNT-1:0] in_s2;
    logic [31:0] tog_cnt;
    logic toggle;
    logic run;
    logic run_d;
    logic entry_pend;
    logic entry_act;
    logic radio_d;
    logic ok_pend;
    logic ok_act;
    logic radio_err;
    logic [3:0] special;
    logic [KEY_COUNT-1:0] aux_en;
    logic [KEY_COUNT-1:0] nav;
    logic mon_active;
    logic [3:0] mon_sel;
    logic [INPUT_COUNT-1:0] force_en;
    logic [INPUT_COUNT-1:0] force_val;
    logic [INPUT_COUNT-1:0] img;
    logic [2:0] ana_sel;
    logic backlight;
    logic [FLAG_COUNT-1:0] flags;
    logic [31:0] prdata;
  } state_type;
endpackage : sys_flag_pkg
`default_nettype wire

// *** verilog/system_status_flag_unit.sv ***
// System status flags, special outputs, keys and input image with an APB register port.
//
// Notes on behaviour
// [R1] One flag always reads one, another always reads zero.
// [R2] A toggle flag is high half a second, then low half a second.
// [R3] The clock-fault flag follows the real time clock data error.
// [R4] The daylight-saving flag is high while summer time is in effect.
// [R5] One flag on any field-network error, another on its power loss cause.
// [R6] Entering run gives a high pulse and a complementary low pulse.
// [R7] Radio decoding flag; at its end an ok pulse or an error flag.
// [R8] Carrier flag follows the modem carrier detect.
// [R9] Network-ready flag follows cellular network availability.
// [R10] Remote-access flag follows cellular access to the controller.
// [R11] Supply flag follows external analog output board power.
// [R12] Eight sensor-defect flags, one per analog-capable input.
// [R13] Exactly 24 flags, indexed consecutively.
// [R14] Disconnect output high detaches from the field network.
// [R15] Backlight force off or on; both low uses the delay; on wins.
// [R16] Display source high hands the screen to the display manager.
// [R17] Eight front-panel keys are readable as program inputs.
// [R18] A key used as a program input stops serving navigation.
// [R19] In monitor mode the confirm key forces the selected input.
// [R20] Up to 15 inputs; the first eight also read as analog values.
// [R21] Each run-entry pulse lasts exactly one program scan.
// [R22] The toggle comes from a clock counter with a one second period.
//
// Chosen here: the APB register port and the address map.
`default_nettype none
module system_status_flag_unit #(
  parameter int unsigned HALF_SECOND_CYCLES = sys_flag_pkg::HALF_SECOND_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire sys_flag_pkg::apb_in_type bus_in,
  output sys_flag_pkg::apb_out_type bus_out,
  // Status pins from outside the clock domain.
  input wire sys_flag_pkg::status_pin_type status_pins,
  input wire logic [sys_flag_pkg::KEY_COUNT-1:0] key_pins,
  input wire logic [sys_flag_pkg::INPUT_COUNT-1:0] input_pins,
  // Program and display logic on the same clock.
  input wire logic scan_start,
  input wire logic backlight_timer_on,
  input wire logic [sys_flag_pkg::ANALOG_COUNT-1:0][sys_flag_pkg::ANALOG_BITS-1:0] analog_value,
  // Values seen by the user program.
  output logic [sys_flag_pkg::FLAG_COUNT-1:0] system_flags,
  output logic [sys_flag_pkg::KEY_COUNT-1:0] key_input,
  output logic [sys_flag_pkg::KEY_COUNT-1:0] key_nav,
  output logic [sys_flag_pkg::INPUT_COUNT-1:0] input_image,
  // Special outputs.
  output logic fieldnet_disconnect_out,
  output logic backlight_on,
  output logic display_source_select
);
  import sys_flag_pkg::*;

  state_type s;
  state_type next;
  status_pin_type st;
  logic access;
  logic wr;

  // True when the address names one of the registers.
  function automatic logic mapped(input logic [ADDR_BITS-1:0] a);
    mapped = (a == OFF_FLAGS) || (a == OFF_SPECIAL) || (a == OFF_KEYS) ||
             (a == OFF_RUN) || (a == OFF_MONITOR) || (a == OFF_INPUTS) ||
             (a == OFF_ANALOG);
  endfunction : mapped

  // Rising edge of a synchronised key, ignored while the key feeds the program.
  function automatic logic key_press(input state_type c, input int k);
    key_press = c.key_s2[k] & ~c.key_d[k] & ~c.aux_en[k];
  endfunction : key_press

  assign st = s.st_s2;
  assign access = bus_in.psel & bus_in.penable;
  assign wr = access & bus_in.pwrite;

  // Zero wait: the read word was captured in the setup cycle.
  assign bus_out.prdata = s.prdata;
  assign bus_out.pready = 1'b1;
  assign bus_out.pslverr = access & ~mapped(bus_in.paddr);

  // All other outputs come straight from state flops.
  assign system_flags = s.flags;
  assign key_input = s.key_s2; // see [R17]
  assign key_nav = s.nav;
  assign input_image = s.img;
  assign fieldnet_disconnect_out = s.special[SPC_DISCONNECT]; // see [R14]
  assign backlight_on = s.backlight;
  assign display_source_select = s.special[SPC_DISPLAY]; // see [R16]

  // Next state of the whole block.
  always_comb begin
    logic entry_rise;
    logic radio_end;
    logic ok_set;
    logic [FLAG_COUNT-1:0] f;
    logic [31:0] rd;
    entry_rise = 1'b0;
    radio_end = 1'b0;
    ok_set = 1'b0;
    f = '0;
    rd = '0;
    next = s;

    // Two-flop synchronisers; only the second stage is read.
    next.st_s1 = status_pins;
    next.st_s2 = s.st_s1;
    next.key_s1 = key_pins;
    next.key_s2 = s.key_s1;
    next.key_d = s.key_s2;
    next.in_s1 = input_pins;
    next.in_s2 = s.in_s1;

    // Free counter on the system clock keeps the period fixed whatever the scan time.
    if (s.tog_cnt >= HALF_SECOND_CYCLES - 32'd1) begin // see [R22]
      next.tog_cnt = '0;
      next.toggle = ~s.toggle; // see [R2]
    end else begin
      next.tog_cnt = s.tog_cnt + 32'h1;
    end

    // A run entry waits for the next scan start and then lasts that one scan.
    next.run_d = s.run;
    entry_rise = s.run & ~s.run_d;
    if (scan_start) begin
      next.entry_act = s.entry_pend | entry_rise; // see [R6] [R21]
      next.entry_pend = 1'b0;
    end else begin
      next.entry_pend = s.entry_pend | entry_rise;
    end

    // Radio decode end: success pulses for one scan, failure holds until a new decode.
    next.radio_d = st.radio_decoding;
    radio_end = s.radio_d & ~st.radio_decoding;
    ok_set = radio_end & ~st.radio_error;
    if (st.radio_decoding & ~s.radio_d) begin
      next.radio_err = 1'b0;
    end
    if (radio_end & st.radio_error) begin
      next.radio_err = 1'b1; // see [R7]
    end
    if (scan_start) begin
      next.ok_act = s.ok_pend | ok_set; // see [R7]
      next.ok_pend = 1'b0;
    end else begin
      next.ok_pend = s.ok_pend | ok_set;
    end

    // Monitor forcing; leaving monitor mode drops every force.
    if (!s.mon_active) begin
      next.force_en = '0;
    end else if (s.mon_sel < 4'(INPUT_COUNT)) begin
      if (key_press(s, KEY_CONFIRM)) begin
        next.force_en[s.mon_sel] = 1'b1; // see [R19]
        next.force_val[s.mon_sel] = ~s.img[s.mon_sel];
      end else if (key_press(s, KEY_CANCEL)) begin
        next.force_en[s.mon_sel] = 1'b0;
      end
    end
    next.img = (s.in_s2 & ~s.force_en) | (s.force_val & s.force_en); // see [R20]
    next.nav = s.key_s2 & ~s.aux_en; // see [R18]

    // Force on wins over force off; with neither the delay timer decides.
    if (s.special[SPC_BL_ON]) begin
      next.backlight = 1'b1; // see [R15]
    end else if (s.special[SPC_BL_OFF]) begin
      next.backlight = 1'b0;
    end else begin
      next.backlight = backlight_timer_on;
    end

    // The flag word, one bit per predefined flag.
    f[FLG_ONE] = 1'b1; // see [R1] [R13]
    f[FLG_ZERO] = 1'b0;
    f[FLG_TOGGLE] = s.toggle;
    f[FLG_CLOCK] = st.rtc_error; // see [R3]
    f[FLG_SUMMER] = st.summer_time; // see [R4]
    f[FLG_COMM] = st.fieldnet_comm_error | st.fieldnet_power_error; // see [R5]
    f[FLG_POWER] = st.fieldnet_power_error;
    f[FLG_ENTRY_HI] = s.entry_act; // see [R6]
    f[FLG_ENTRY_LO] = ~s.entry_act;
    f[FLG_RADIO_BUSY] = st.radio_decoding; // see [R7]
    f[FLG_RADIO_OK] = s.ok_act;
    f[FLG_CARRIER] = st.modem_carrier; // see [R8]
    f[FLG_CELL_READY] = st.cell_ready; // see [R9]
    f[FLG_CELL_REMOTE] = st.cell_remote; // see [R10]
    f[FLG_RADIO_ERR] = s.radio_err;
    f[FLG_SUPPLY] = st.ext_supply; // see [R11]
    f[FLG_SENSOR0 +: SENSOR_COUNT] = st.sensor_defect; // see [R12]
    next.flags = f;

    // Register writes take effect at the access edge.
    if (wr) begin
      unique case (bus_in.paddr)
        OFF_SPECIAL: next.special = bus_in.pwdata[3:0];
        OFF_KEYS: next.aux_en = bus_in.pwdata[KEY_COUNT-1:0];
        OFF_RUN: next.run = bus_in.pwdata[0];
        OFF_MONITOR: begin
          next.mon_active = bus_in.pwdata[MON_ACTIVE];
          next.mon_sel = bus_in.pwdata[MON_SEL_LSB +: 4];
        end
        OFF_ANALOG: next.ana_sel = bus_in.pwdata[2:0];
        default: begin
        end
      endcase
    end

    // Read word captured in the setup cycle; unmapped reads return zero.
    unique case (bus_in.paddr)
      OFF_FLAGS: rd[FLAG_COUNT-1:0] = s.flags;
      OFF_SPECIAL: rd[3:0] = s.special;
      OFF_KEYS: begin
        rd[KEY_COUNT-1:0] = s.aux_en;
        rd[KEYS_STATE_LSB +: KEY_COUNT] = s.key_s2;
      end
      OFF_RUN: rd[0] = s.run;
      OFF_MONITOR: begin
        rd[MON_ACTIVE] = s.mon_active;
        rd[MON_SEL_LSB +: 4] = s.mon_sel;
        rd[MON_FORCE_LSB +: INPUT_COUNT] = s.force_en;
      end
      OFF_INPUTS: rd[INPUT_COUNT-1:0] = s.img;
      OFF_ANALOG: begin
        rd[2:0] = s.ana_sel;
        rd[ANALOG_VAL_LSB +: ANALOG_BITS] = analog_value[s.ana_sel]; // see [R20]
      end
      default: rd = '0;
    endcase
    if (bus_in.psel & ~bus_in.penable) begin
      next.prdata = rd;
    end
  end

  // One register for the whole state; reset loads constants only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.flags <= FLAGS_RST; // see [R1]
    end else begin
      s <= next;
    end
  end

  // The constant flags never move.
  property p_const_flags;
    @(posedge pclk) disable iff (!presetn)
      system_flags[FLG_ONE] && !system_flags[FLG_ZERO];
  endproperty
  a_const_flags: assert property (p_const_flags) else $error("constant flags wrong"); // see [R1]

  // The toggle only turns when the counter reaches the half period.
  property p_toggle_step;
    @(posedge pclk) disable iff (!presetn)
      $changed(s.toggle) |-> $past(s.tog_cnt) == HALF_SECOND_CYCLES - 32'd1;
  endproperty
  a_toggle_step: assert property (p_toggle_step) else $error("toggle turned early"); // see [R2] [R22]

  // The clock-fault flag follows the synchronised error one cycle later.
  property p_clock_fault;
    @(posedge pclk) disable iff (!presetn)
      ##1 system_flags[FLG_CLOCK] == $past(st.rtc_error);
  endproperty
  a_clock_fault: assert property (p_clock_fault) else $error("clock fault flag wrong"); // see [R3]

  // A power-loss error is also a communication error.
  property p_power_comm;
    @(posedge pclk) disable iff (!presetn)
      system_flags[FLG_POWER] |-> system_flags[FLG_COMM];
  endproperty
  a_power_comm: assert property (p_power_comm) else $error("power error without comm error"); // see [R5]

  // The two run-entry flags are always complementary.
  property p_entry_pair;
    @(posedge pclk) disable iff (!presetn)
      system_flags[FLG_ENTRY_HI] != system_flags[FLG_ENTRY_LO];
  endproperty
  a_entry_pair: assert property (p_entry_pair) else $error("run entry flags not complementary"); // see [R6]

  // A run-entry pulse starts and ends only at a scan start.
  property p_entry_scan;
    @(posedge pclk) disable iff (!presetn)
      $changed(s.entry_act) |-> $past(scan_start);
  endproperty
  a_entry_scan: assert property (p_entry_scan) else $error("run entry pulse off scan"); // see [R21]

  // The radio error rises only at the end of a decode.
  property p_radio_err;
    @(posedge pclk) disable iff (!presetn)
      $rose(s.radio_err) |-> $past(s.radio_d) && !$past(st.radio_decoding) && $past(st.radio_error);
  endproperty
  a_radio_err: assert property (p_radio_err) else $error("radio error without decode end"); // see [R7]

  // Force on lights the backlight on the next edge whatever else is set.
  property p_backlight_on;
    @(posedge pclk) disable iff (!presetn)
      s.special[SPC_BL_ON] |=> backlight_on;
  endproperty
  a_backlight_on: assert property (p_backlight_on) else $error("backlight force on lost"); // see [R15]

  // Force off alone darkens the backlight on the next edge.
  property p_backlight_off;
    @(posedge pclk) disable iff (!presetn)
      s.special[SPC_BL_OFF] && !s.special[SPC_BL_ON] |=> !backlight_on;
  endproperty
  a_backlight_off: assert property (p_backlight_off) else $error("backlight force off lost"); // see [R15]

  // A key that feeds the program never shows on the navigation lines.
  property p_nav_masked;
    @(posedge pclk) disable iff (!presetn)
      ##1 (key_nav & $past(s.aux_en)) == '0;
  endproperty
  a_nav_masked: assert property (p_nav_masked) else $error("program key still navigates"); // see [R18]

  // A write to the special register reaches the disconnect pin one edge later.
  property p_disconnect;
    @(posedge pclk) disable iff (!presetn)
      wr && bus_in.paddr == OFF_SPECIAL |=> fieldnet_disconnect_out == $past(bus_in.pwdata[SPC_DISCONNECT]);
  endproperty
  a_disconnect: assert property (p_disconnect) else $error("disconnect output not updated"); // see [R14]

  // The toggle flag shows the toggle one edge later.
  property p_toggle_flag;
    @(posedge pclk) disable iff (!presetn)
      ##1 system_flags[FLG_TOGGLE] == $past(s.toggle);
  endproperty
  a_toggle_flag: assert property (p_toggle_flag) else $error("toggle flag lags the toggle"); // see [R2]

  // The half period counter never passes its wrap point, so the period cannot stretch.
  property p_tog_range;
    @(posedge pclk) disable iff (!presetn)
      s.tog_cnt < HALF_SECOND_CYCLES;
  endproperty
  a_tog_range: assert property (p_tog_range) else $error("toggle counter out of range"); // see [R22]

  // The daylight-saving flag follows the synchronised summer time level.
  property p_summer;
    @(posedge pclk) disable iff (!presetn)
      ##1 system_flags[FLG_SUMMER] == $past(st.summer_time);
  endproperty
  a_summer: assert property (p_summer) else $error("summer time flag wrong"); // see [R4]

  // Both cellular flags follow their synchronised levels.
  property p_cell;
    @(posedge pclk) disable iff (!presetn)
      ##1 system_flags[FLG_CELL_READY] == $past(st.cell_ready) && system_flags[FLG_CELL_REMOTE] == $past(st.cell_remote);
  endproperty
  a_cell: assert property (p_cell) else $error("cellular flags wrong"); // see [R9] [R10]

  // The supply flag follows the synchronised supply level.
  property p_supply;
    @(posedge pclk) disable iff (!presetn)
      ##1 system_flags[FLG_SUPPLY] == $past(st.ext_supply);
  endproperty
  a_supply: assert property (p_supply) else $error("supply flag wrong"); // see [R11]

  // Each sensor-defect flag follows its own synchronised channel.
  property p_sensor;
    @(posedge pclk) disable iff (!presetn)
      ##1 system_flags[FLG_SENSOR0 +: SENSOR_COUNT] == $past(st.sensor_defect);
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor defect flags wrong"); // see [R12]

  // A write to the special register reaches the display source pin one edge later.
  property p_display;
    @(posedge pclk) disable iff (!presetn)
      wr && bus_in.paddr == OFF_SPECIAL |=> display_source_select == $past(bus_in.pwdata[SPC_DISPLAY]);
  endproperty
  a_display: assert property (p_display) else $error("display source output not updated"); // see [R16]

  // Outside monitor mode no input stays forced.
  property p_force_idle;
    @(posedge pclk) disable iff (!presetn)
      !s.mon_active |=> s.force_en == '0;
  endproperty
  a_force_idle: assert property (p_force_idle) else $error("force left outside monitor mode"); // see [R19]
endmodule : system_status_flag_unit
`default_nettype wire

// *** bench/scan_program_model.sv ***
// Model of the user program that runs one scan after another and feeds analog values.
`default_nettype none
module scan_program_model #(
  parameter int SCAN_CYCLES = 10
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Program side of the unit.
  output logic scan_start,
  output logic [sys_flag_pkg::ANALOG_COUNT-1:0][sys_flag_pkg::ANALOG_BITS-1:0] analog_value
);
  timeunit 1ns;
  timeprecision 1ps;
  import sys_flag_pkg::*;
  int cnt;

  // A scan starts every SCAN_CYCLES clocks, so a one-scan pulse has a known width.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      scan_start <= 1'b0;
    end else begin
      cnt <= (cnt == SCAN_CYCLES - 1) ? 0 : cnt + 1;
      scan_start <= (cnt == SCAN_CYCLES - 1);
    end
  end

  // Each analog channel carries its own index so a wrong channel shows at once.
  always_comb begin
    for (int i = 0; i < ANALOG_COUNT; i++) begin
      analog_value[i] = 10'h200 + 10'(i);
    end
  end
endmodule : scan_program_model
`default_nettype wire

// *** bench/tb_system_status_flag_unit.sv ***
// Self-checking testbench for the system status flag unit.
`default_nettype none
module tb_system_status_flag_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import sys_flag_pkg::*;
  localparam int HALF = 8;
  localparam int SCAN = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_in_type bus_in = '0;
  apb_out_type bus_out;
  status_pin_type status_pins = '0;
  logic [KEY_COUNT-1:0] key_pins = '0;
  logic [INPUT_COUNT-1:0] input_pins = '0;
  logic scan_start;
  logic backlight_timer_on = 1'b0;
  logic [ANALOG_COUNT-1:0][ANALOG_BITS-1:0] analog_value;
  logic [FLAG_COUNT-1:0] system_flags;
  logic [KEY_COUNT-1:0] key_input;
  logic [KEY_COUNT-1:0] key_nav;
  logic [INPUT_COUNT-1:0] input_image;
  logic fieldnet_disconnect_out;
  logic backlight_on;
  logic display_source_select;
  int errors = 0;
  int cmp_count = 0;
  logic [31:0] q;
  logic err;

  // Clock at 200 MHz.
  always #2.5 pclk = ~pclk;

  system_status_flag_unit #(.HALF_SECOND_CYCLES(HALF)) system_status_flag_unit_inst (
    .pclk(pclk), .presetn(presetn), .bus_in(bus_in), .bus_out(bus_out), .status_pins(status_pins),
    .key_pins(key_pins), .input_pins(input_pins), .scan_start(scan_start),
    .backlight_timer_on(backlight_timer_on), .analog_value(analog_value), .system_flags(system_flags),
    .key_input(key_input), .key_nav(key_nav), .input_image(input_image),
    .fieldnet_disconnect_out(fieldnet_disconnect_out), .backlight_on(backlight_on),
    .display_source_select(display_source_select));

  scan_program_model #(.SCAN_CYCLES(SCAN)) scan_program_model_inst (
    .pclk(pclk), .presetn(presetn), .scan_start(scan_start), .analog_value(analog_value));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    bus_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    bus_in.penable <= 1'b1;
    @(posedge pclk);
    while (bus_out.pready !== 1'b1) @(posedge pclk);
    q = bus_out.prdata;
    err = bus_out.pslverr;
    bus_in.psel <= 1'b0;
    bus_in.penable <= 1'b0;
  endtask : apb

  // Waits for a flag to reach a level, then counts the clocks it stays there.
  task pulse_len(input int b, input logic lvl, output int n);
    int w;
    w = 0;
    n = 0;
    while (system_flags[b] !== lvl && w < 200) begin
      @(posedge pclk);
      w++;
    end
    while (system_flags[b] === lvl && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask : pulse_len

  task test_constants_toggle();
    int n;
    chk($bits(system_flags), 32'd24);
    apb(1'b1, OFF_FLAGS, 32'h0);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(q & 32'hfffffffb, 32'h101);
    pulse_len(FLG_TOGGLE, ~system_flags[FLG_TOGGLE], n);
    chk(n, HALF);
    pulse_len(FLG_TOGGLE, ~system_flags[FLG_TOGGLE], n);
    chk(n, HALF);
  endtask : test_constants_toggle

  // Each status pin but the two radio pins alone, the sensor pins in two groups, then released; the toggle bit is masked out.
  task test_status_pins();
    logic [17:0] pin_tab[10];
    logic [23:0] flg_tab[10];
    pin_tab = '{18'h20000, 18'h10000, 18'h08000, 18'h04000, 18'h02000, 18'h01000, 18'h00800,
                18'h00400, 18'h00081, 18'h0007e};
    flg_tab = '{24'h8, 24'h10, 24'h20, 24'h60, 24'h800, 24'h1000, 24'h2000, 24'h8000, 24'h810000,
                24'h7e0000};
    for (int k = 0; k < 10; k++) begin
      status_pins <= pin_tab[k];
      repeat (5) @(posedge pclk);
      chk(system_flags & 24'hfffffb, flg_tab[k] | 24'h101);
    end
    status_pins <= '0;
    repeat (5) @(posedge pclk);
    chk(system_flags & 24'hfffffb, 24'h101);
  endtask : test_status_pins

  task test_radio();
    int n;
    status_pins <= 18'h00200;
    repeat (5) @(posedge pclk);
    chk(system_flags[FLG_RADIO_BUSY], 1'b1);
    status_pins <= '0;
    pulse_len(FLG_RADIO_OK, 1'b1, n);
    chk(n, SCAN);
    status_pins <= 18'h00300;
    repeat (5) @(posedge pclk);
    status_pins <= 18'h00100;
    repeat (5) @(posedge pclk);
    chk({system_flags[FLG_RADIO_ERR], system_flags[FLG_RADIO_OK]}, 2'b10);
    status_pins <= '0;
  endtask : test_radio

  task test_run_entry();
    int n;
    n = 0;
    apb(1'b1, OFF_RUN, 32'h1);
    while (system_flags[FLG_ENTRY_HI] !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk(system_flags[FLG_ENTRY_LO], 1'b0);
    pulse_len(FLG_ENTRY_HI, 1'b1, n);
    chk(n, SCAN);
    chk({system_flags[FLG_ENTRY_HI], system_flags[FLG_ENTRY_LO]}, 2'b01);
  endtask : test_run_entry

  // Every combination of the special bits, with the delay timer request low and high.
  task test_special();
    logic [3:0] v;
    for (int k = 0; k < 32; k++) begin
      v = 4'(k);
      backlight_timer_on <= k[4];
      apb(1'b1, OFF_SPECIAL, {28'h0, v});
      apb(1'b0, OFF_SPECIAL, 32'h0);
      repeat (2) @(posedge pclk);
      chk(q, {28'h0, v});
      chk(fieldnet_disconnect_out, v[SPC_DISCONNECT]);
      chk(backlight_on, v[SPC_BL_ON] | (~v[SPC_BL_OFF] & k[4]));
      chk(display_source_select, v[SPC_DISPLAY]);
    end
  endtask : test_special

  task test_keys_monitor();
    key_pins <= 8'ha5;
    apb(1'b1, OFF_KEYS, 32'h0f);
    repeat (5) @(posedge pclk);
    chk(key_input, 8'ha5);
    chk(key_nav, 8'ha0);
    apb(1'b0, OFF_KEYS, 32'h0);
    chk(q, 32'ha50f);
    apb(1'b1, OFF_KEYS, 32'h0);
    key_pins <= 8'h00;
    input_pins <= 15'h1234;
    apb(1'b1, OFF_MONITOR, 32'h21);
    repeat (5) @(posedge pclk);
    chk(input_image, 15'h1234);
    key_pins <= 8'h01;
    repeat (5) @(posedge pclk);
    chk(input_image, 15'h1230);
    apb(1'b0, OFF_MONITOR, 32'h0);
    chk(q, 32'h00040021);
    key_pins <= 8'h02;
    repeat (5) @(posedge pclk);
    chk(input_image, 15'h1234);
    apb(1'b1, OFF_ANALOG, 32'h7);
    apb(1'b0, OFF_ANALOG, 32'h0);
    chk(q, 32'h02070007);
    apb(1'b0, 12'h01c, 32'h0);
    chk(q, 32'h0);
    chk(err, 1'b1);
  endtask : test_keys_monitor

  task wrap_up();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Main sequence after the reset has been held for five clocks.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_constants_toggle();
    test_status_pins();
    test_radio();
    test_run_entry();
    test_special();
    test_keys_monitor();
    wrap_up();
  end

  // The whole run needs a few hundred clocks; this limit leaves a wide margin.
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    wrap_up();
  end
endmodule : tb_system_status_flag_unit
`default_nettype wire
